// >>> src/epc_sequencer.v
// Experiment payload power sequencer with its command link master.
// What this block does
// - Controller alone starts every link transaction.
// - Multi-byte fields and bits go MSB first.
// - Controller retries, then flags bad replies.
// - Each message starts with a header.
// - Each message carries a CRC8 check.
// - CRC also covers the address byte.
// - Link runs at 400 kbit/s.
// - Payload answers fixed address 0x2A.
// - Enable output high powers the payload.
// - No power-on while bus voltage is low.
// - Low voltage while running: cease, then off.
// - Power-on drives and holds enable high.
// - Link stays silent for settle interval.
// - Set-time command ends power-on.
// - Then set-run-state active starts experiment.
// - Cease starts with set-run-state halt.
// - Silent wait after the halt command.
// - Set-run-state standby ends the cease sequence.
// - Power-off drives enable low.
// - Run state argument: standby, active, halt.
// - Set-time carries reset count and seconds.
// - Header carries format version and build.
`timescale 1ns/100ps
`include "epc_defines.vh"
module epc_sequencer #(
   parameter SETTLE_CYCLES = `EPC_SETTLE_CYC,
   parameter HALT_CYCLES = `EPC_HALT_CYC,
   parameter [15:0] SW_BUILD = 16'h0001
) (
   // Clock and reset.
   input wire clk_in,
   input wire rst_n_in,
   // Requests from housekeeping software.
   input wire power_on_req_in,
   input wire power_off_req_in,
   input wire bus_voltage_ok_in,
   input wire [15:0] reset_count_in,
   input wire [31:0] mission_time_in,
   // Payload power enable.
   output reg payload_enable_out,
   // Link pins, output enable high while driving low.
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe_out,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   // Status.
   output reg [3:0] seq_state_out,
   output reg busy_out,
   output reg link_error_out
);
   // Sequencer states.
   localparam S_OFF = 4'h0;
   localparam S_SETTLE = 4'h1;
   localparam S_TIME = 4'h2;
   localparam S_ACTIVE = 4'h3;
   localparam S_RUN = 4'h4;
   localparam S_HALT = 4'h5;
   localparam S_HWAIT = 4'h6;
   localparam S_STBY = 4'h7;
   localparam S_POWOFF = 4'h8;
   // Link engine phases.
   localparam L_IDLE = 3'h0;
   localparam L_START = 3'h1;
   localparam L_BITS = 3'h2;
   localparam L_ACK = 3'h3;
   localparam L_STOP = 3'h4;
   localparam L_RDLOAD = 3'h5;
   localparam [15:0] MSG_VER = `EPC_MSG_VERSION; // Header format version.

   // One CRC8 step over a byte, most significant bit first.
   function [7:0] crc_step;
      input [7:0] crc;
      input [7:0] data;
      integer i;
      reg [7:0] c;
      begin
         c = crc ^ data;
         for (i = 0; i < 8; i = i + 1) begin
            c = c[7] ? ((c << 1) ^ `EPC_CRC_POLY) : (c << 1);
         end
         crc_step = c;
      end
   endfunction

   reg [3:0] state; // Sequencer state.
   reg [31:0] wait_cnt; // Quiet interval counter.
   reg [2:0] lphase; // Link engine phase.
   reg [7:0] qcnt; // Quarter bit period counter.
   reg [1:0] quarter; // Quarter within a bit.
   reg [2:0] bitn; // Bit index within a byte.
   reg [7:0] shreg; // Outgoing byte.
   reg [4:0] byte_idx; // Byte index of the frame.
   reg [7:0] crc; // Running CRC.
   reg send_req; // Pulse asking the link to send a frame.
   reg done; // Frame finished, one pulse.
   reg nack; // Some byte went unacknowledged.
   reg [1:0] tries; // Retries used on this frame.
   reg [15:0] run_arg; // Run state argument for this frame.
   reg is_time; // Frame is set-time.
   reg build; // Filling the message memory.
   reg [4:0] wr_idx; // Byte being filled.
   reg [7:0] next_byte; // Byte to store while filling.
   wire [7:0] rom_data; // Byte read back from memory.

   // Message memory holding header, command and arguments.
   epc_msg_rom u_rom (
      .clk_in(clk_in),
      .wr_en_in(build),
      .wr_addr_in(wr_idx),
      .wr_data_in(next_byte),
      .rd_addr_in(byte_idx),
      .rd_data_out(rom_data)
   );

   // Frame layout, every field most significant byte first.
   always @* begin
      case (wr_idx)
         5'h00: next_byte = {`EPC_SLAVE_ADDR, 1'b0};
         5'h01: next_byte = MSG_VER[15:8];
         5'h02: next_byte = MSG_VER[7:0];
         5'h03: next_byte = SW_BUILD[15:8];
         5'h04: next_byte = SW_BUILD[7:0];
         5'h05: next_byte = is_time ? 8'h01 : 8'h00;
         5'h06: next_byte = is_time ? 8'h00 : 8'h80;
         5'h07: next_byte = is_time ? reset_count_in[15:8] : run_arg[15:8];
         5'h08: next_byte = is_time ? reset_count_in[7:0] : run_arg[7:0];
         5'h09: next_byte = mission_time_in[31:24];
         5'h0A: next_byte = mission_time_in[23:16];
         5'h0B: next_byte = mission_time_in[15:8];
         5'h0C: next_byte = mission_time_in[7:0];
         default: next_byte = 8'h00;
      endcase
   end

   // Power and command sequencer.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= S_OFF;
         wait_cnt <= 32'h0;
         payload_enable_out <= 1'b0;
         send_req <= 1'b0;
         run_arg <= 16'h0000;
         is_time <= 1'b0;
         tries <= 2'h0;
         link_error_out <= 1'b0;
         seq_state_out <= S_OFF;
         busy_out <= 1'b0;
      end else begin
         send_req <= 1'b0;
         seq_state_out <= state;
         busy_out <= (state != S_OFF) && (state != S_RUN);
         if (done) begin
            if (nack && tries != `EPC_RETRIES) begin
               tries <= tries + 2'h1;
               send_req <= 1'b1;
            end else begin
               link_error_out <= link_error_out | nack;
               tries <= 2'h0;
            end
         end
         case (state)
            S_OFF: begin
               payload_enable_out <= 1'b0;
               if (power_on_req_in && bus_voltage_ok_in) begin
                  payload_enable_out <= 1'b1;
                  link_error_out <= 1'b0;
                  wait_cnt <= 32'h0;
                  state <= S_SETTLE;
               end
            end
            S_SETTLE: begin
               wait_cnt <= wait_cnt + 32'h1;
               if (wait_cnt == SETTLE_CYCLES - 1) begin
                  is_time <= 1'b1;
                  send_req <= 1'b1;
                  state <= S_TIME;
               end
            end
            S_TIME: begin
               if (done && !(nack && tries != `EPC_RETRIES)) begin
                  is_time <= 1'b0;
                  run_arg <= `EPC_RUN_ACTIVE;
                  send_req <= 1'b1;
                  state <= S_ACTIVE;
               end
            end
            S_ACTIVE: begin
               if (done && !(nack && tries != `EPC_RETRIES)) begin
                  state <= S_RUN;
               end
            end
            S_RUN: begin
               if (!bus_voltage_ok_in || power_off_req_in) begin
                  run_arg <= `EPC_RUN_HALT;
                  send_req <= 1'b1;
                  state <= S_HALT;
               end
            end
            S_HALT: begin
               if (done && !(nack && tries != `EPC_RETRIES)) begin
                  wait_cnt <= 32'h0;
                  state <= S_HWAIT;
               end
            end
            S_HWAIT: begin
               wait_cnt <= wait_cnt + 32'h1;
               if (wait_cnt == HALT_CYCLES - 1) begin
                  run_arg <= `EPC_RUN_STANDBY;
                  send_req <= 1'b1;
                  state <= S_STBY;
               end
            end
            S_STBY: begin
               if (done && !(nack && tries != `EPC_RETRIES)) begin
                  state <= S_POWOFF;
               end
            end
            S_POWOFF: begin
               payload_enable_out <= 1'b0;
               state <= S_OFF;
            end
            default: state <= S_OFF;
         endcase
      end
   end

   // Link master: fills the frame, then shifts bytes out with CRC last.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         lphase <= L_IDLE;
         qcnt <= 8'h00;
         quarter <= 2'h0;
         bitn <= 3'h7;
         shreg <= 8'h00;
         byte_idx <= 5'h00;
         crc <= `EPC_CRC_INIT;
         done <= 1'b0;
         nack <= 1'b0;
         build <= 1'b0;
         wr_idx <= 5'h00;
         scl_out <= 1'b0;
         scl_oe_out <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end else begin
         done <= 1'b0;
         if (build) begin
            wr_idx <= wr_idx + 5'h01;
            if (wr_idx == 5'h0C) begin
               build <= 1'b0;
               byte_idx <= 5'h00;
               lphase <= L_RDLOAD;
            end
         end
         qcnt <= (qcnt == `EPC_QUARTER - 1) ? 8'h00 : qcnt + 8'h01;
         case (lphase)
            L_IDLE: begin
               scl_oe_out <= 1'b0;
               sda_oe_out <= 1'b0;
               if (send_req) begin
                  build <= 1'b1;
                  wr_idx <= 5'h00;
                  nack <= 1'b0;
                  crc <= `EPC_CRC_INIT;
               end
            end
            L_RDLOAD: begin
               if (qcnt == 8'h00) begin
                  sda_oe_out <= 1'b1; // Start: data low while clock high.
                  lphase <= L_START;
               end
            end
            L_START: begin
               if (qcnt == 8'h00) begin
                  scl_oe_out <= 1'b1;
                  shreg <= rom_data;
                  crc <= crc_step(crc, rom_data);
                  byte_idx <= byte_idx + 5'h01;
                  bitn <= 3'h7;
                  quarter <= 2'h0;
                  lphase <= L_BITS;
               end
            end
            L_BITS, L_ACK: begin
               if (qcnt == 8'h00) begin
                  quarter <= quarter + 2'h1;
                  case (quarter)
                     2'h0: sda_oe_out <= (lphase == L_ACK) ? 1'b0
                        : !shreg[bitn];
                     2'h1: scl_oe_out <= 1'b0;
                     2'h2: if (lphase == L_ACK && sda_in) nack <= 1'b1;
                     default: begin
                        scl_oe_out <= 1'b1;
                        if (lphase == L_ACK) begin
                           if (byte_idx == 5'h0E || nack) begin
                              lphase <= L_STOP;
                           end else begin
                              shreg <= (byte_idx == 5'h0D) ? crc : rom_data;
                              crc <= crc_step(crc, rom_data);
                              byte_idx <= byte_idx + 5'h01;
                              bitn <= 3'h7;
                              lphase <= L_BITS;
                           end
                        end else if (bitn == 3'h0) begin
                           lphase <= L_ACK;
                        end else begin
                           bitn <= bitn - 3'h1;
                        end
                     end
                  endcase
               end
            end
            L_STOP: begin
               if (qcnt == 8'h00) begin
                  quarter <= quarter + 2'h1;
                  case (quarter)
                     2'h0: sda_oe_out <= 1'b1;
                     2'h1: scl_oe_out <= 1'b0;
                     2'h2: sda_oe_out <= 1'b0;
                     default: begin
                        done <= 1'b1;
                        lphase <= L_IDLE;
                     end
                  endcase
               end
            end
            default: lphase <= L_IDLE;
         endcase
      end
   end
endmodule

// >>> src/epc_defines.vh
// Constants for the experiment power and command link sequencer.
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH
`define EPC_SLAVE_ADDR 7'h2A
`define EPC_CMD_SET_RUN 16'h0080
`define EPC_CMD_SET_TIME 16'h0100
`define EPC_RUN_STANDBY 16'h0001
`define EPC_RUN_ACTIVE 16'h0003
`define EPC_RUN_HALT 16'h0004
`define EPC_MSG_VERSION 16'h006D
`define EPC_CLK_HZ 40000000
`define EPC_SCL_HZ 400000
`define EPC_QUARTER ((`EPC_CLK_HZ / `EPC_SCL_HZ) / 4)
`define EPC_SETTLE_MS 100
`define EPC_HALT_MS 10000
`define EPC_SETTLE_CYC ((`EPC_CLK_HZ / 1000) * `EPC_SETTLE_MS)
`define EPC_HALT_CYC ((`EPC_CLK_HZ / 1000) * `EPC_HALT_MS)
`define EPC_CRC_POLY 8'h07
`define EPC_CRC_INIT 8'h00
`define EPC_MSG_LEN 5'h0F
`define EPC_RETRIES 2'h2
`endif

// >>> src/epc_msg_rom.v
// Small message memory holding the bytes of the next command frame.
`timescale 1ns/100ps
module epc_msg_rom (
   // Clock.
   input wire clk_in,
   // Write side.
   input wire wr_en_in,
   input wire [4:0] wr_addr_in,
   input wire [7:0] wr_data_in,
   // Read side.
   input wire [4:0] rd_addr_in,
   output reg [7:0] rd_data_out
);
   // Message byte storage.
   reg [7:0] mem [0:31];

   // Writes land at once; read data come out of a register.
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// >>> tb/epc_seq_sva.sv
// Checker for the payload power sequencer, attached by bind.
`timescale 1ns/100ps
module epc_seq_sva #(
   parameter SETTLE_CYCLES = 50,
   parameter HALT_CYCLES = 60
) (
   // Clock and reset.
   input wire clk_in,
   input wire rst_n_in,
   // Watched inputs.
   input wire power_off_req_in,
   input wire bus_voltage_ok_in,
   // Watched outputs.
   input wire payload_enable_out,
   input wire scl_oe_out,
   input wire sda_oe_out,
   input wire [3:0] seq_state_out,
   input wire busy_out,
   input wire link_error_out
);
   integer scnt; // Cycles with the enable high, saturating.
   integer hcnt; // Cycles spent in the halt wait.
   // Count the settle time and the halt wait.
   always @(posedge clk_in) begin
      if (!rst_n_in || !payload_enable_out) begin
         scnt <= 0;
      end else if (scnt < SETTLE_CYCLES) begin
         scnt <= scnt + 1;
      end
      if (!rst_n_in || seq_state_out != 4'h6) begin
         hcnt <= 0;
      end else begin
         hcnt <= hcnt + 1;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // The clock line is let go by the controller.
   sequence scl_release;
      $fell(scl_oe_out);
   endsequence
   // A cease cause is seen while running.
   sequence cease_cause;
      seq_state_out == 4'h4 && (!bus_voltage_ok_in || power_off_req_in);
   endsequence
   volt_gate_a: assert property ($rose(payload_enable_out) |->
      $past(bus_voltage_ok_in)) else $error("enable rose on low voltage");
   off_refuse_a: assert property (seq_state_out == 4'h0 &&
      !payload_enable_out && !bus_voltage_ok_in |=> !payload_enable_out)
      else $error("enable rose while refused");
   settle_quiet_a: assert property (payload_enable_out &&
      scnt < SETTLE_CYCLES |-> !scl_oe_out && !sda_oe_out)
      else $error("link busy during settle time");
   enable_hold_a: assert property (seq_state_out >= 4'h2 &&
      seq_state_out <= 4'h7 |-> payload_enable_out)
      else $error("enable low while payload in use");
   cease_go_a: assert property (cease_cause |->
      ##[1:3] seq_state_out == 4'h5) else $error("cease not started");
   halt_wait_a: assert property ($past(seq_state_out) == 4'h6 &&
      seq_state_out != 4'h6 |-> hcnt >= HALT_CYCLES - 1)
      else $error("halt wait too short");
   hwait_quiet_a: assert property (seq_state_out == 4'h6 |->
      !scl_oe_out && !sda_oe_out) else $error("link busy in halt wait");
   idle_quiet_a: assert property (seq_state_out == 4'h0 |->
      !busy_out && !scl_oe_out && !sda_oe_out)
      else $error("activity while off");
   scl_rate_a: assert property (scl_release |->
      (!scl_oe_out) throughout (##24 1'b1)) else $error("clock high too short");
   error_keep_a: assert property (link_error_out |=>
      link_error_out) else $error("link error flag dropped");
endmodule
bind epc_sequencer epc_seq_sva #(.SETTLE_CYCLES(SETTLE_CYCLES),
   .HALT_CYCLES(HALT_CYCLES)) u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .power_off_req_in(power_off_req_in), .bus_voltage_ok_in(bus_voltage_ok_in),
   .payload_enable_out(payload_enable_out), .scl_oe_out(scl_oe_out),
   .sda_oe_out(sda_oe_out), .seq_state_out(seq_state_out),
   .busy_out(busy_out), .link_error_out(link_error_out));

// >>> tb/epc_payload_model.sv
// Behavioural payload board: a link slave that records each frame.
`timescale 1ns/100ps
`include "epc_defines.vh"
module epc_payload_model (
   // Link wires.
   input wire scl_in,
   input wire sda_in,
   // Bench control: refuse every byte.
   input wire nack_in,
   // Power enable seen by the payload.
   input wire power_in,
   // Acknowledge pull-down.
   output reg ack_oe_out
);
   reg [7:0] frame [0:15]; // Bytes of the latest frame.
   reg [7:0] sh; // Incoming byte.
   integer bitc, nb, n_frames, n_starts;
   initial begin
      ack_oe_out = 1'b0;
      bitc = 0;
      nb = 0;
      n_frames = 0;
      n_starts = 0;
   end
   // A start condition opens a new frame.
   always @(negedge sda_in) begin
      if (scl_in === 1'b1) begin
         bitc = 0;
         nb = 0;
         n_starts = n_starts + 1;
      end
   end
   // A stop condition closes the frame.
   always @(posedge sda_in) begin
      if (scl_in === 1'b1) begin
         n_frames = n_frames + 1;
      end
   end
   // Sample data bits, first bit is the most significant.
   always @(posedge scl_in) begin
      if (bitc < 8) begin
         sh = {sh[6:0], sda_in};
         bitc = bitc + 1;
         if (bitc == 8 && nb < 16) begin
            frame[nb] = sh;
         end
         if (bitc == 8) begin
            nb = nb + 1;
         end
      end else begin
         bitc = 0;
      end
   end
   // Acknowledge own address and every byte after the first of any frame; else ignore.
   always @(negedge scl_in) begin
      ack_oe_out <= power_in === 1'b1 &&
         bitc == 8 && !nack_in &&
         (nb > 1 || frame[0] == {`EPC_SLAVE_ADDR, 1'b0});
   end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the payload power sequencer.
`timescale 1ns/100ps
`include "epc_defines.vh"
module tb_top;
   localparam SET_C = 50; // Shortened settle time.
   localparam HLT_C = 60; // Shortened halt wait.
   reg clk_in, rst_n_in, power_on_req_in, power_off_req_in;
   reg bus_voltage_ok_in, nack_in;
   reg [15:0] reset_count_in;
   reg [31:0] mission_time_in;
   wire payload_enable_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
   wire busy_out, link_error_out, ack_oe;
   wire [3:0] seq_state_out;
   wire scl = ~scl_oe_out; // Pulled up when released.
   wire sda = ~(sda_oe_out | ack_oe); // Open drain with pull-up.
   integer miscompares, n_checks, seen, s, i;
   epc_sequencer #(.SETTLE_CYCLES(SET_C), .HALT_CYCLES(HLT_C)) dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .power_on_req_in(power_on_req_in),
      .power_off_req_in(power_off_req_in), .bus_voltage_ok_in(bus_voltage_ok_in),
      .reset_count_in(reset_count_in), .mission_time_in(mission_time_in),
      .payload_enable_out(payload_enable_out), .scl_in(scl), .scl_out(scl_out),
      .scl_oe_out(scl_oe_out), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .seq_state_out(seq_state_out),
      .busy_out(busy_out), .link_error_out(link_error_out));
   epc_payload_model m (.scl_in(scl), .sda_in(sda), .nack_in(nack_in),
      .power_in(payload_enable_out), .ack_oe_out(ack_oe));
   // Free-running 40 MHz clock.
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // Compare one byte and count the outcome.
   task check_byte(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Advance to the n-th next falling edge.
   task tick(input integer n);
      begin
         repeat (n) @(negedge clk_in);
      end
   endtask
   // One CRC step, polynomial x^8+x^2+x+1.
   function [7:0] crc8(input [7:0] c, input [7:0] d);
      integer k;
      begin
         crc8 = c ^ d;
         for (k = 0; k < 8; k = k + 1) begin
            crc8 = {crc8[6:0], 1'b0} ^ (crc8[7] ? 8'h07 : 8'h00);
         end
      end
   endfunction
   // Wait for the next frame and judge its bytes.
   task chk_frame(input [15:0] cmd, input [15:0] arg, input full);
      reg [103:0] e;
      reg [7:0] c;
      integer j;
      begin
         for (i = 0; i < 20000 && m.n_frames <= seen; i = i + 1) begin
            tick(1);
         end
         seen = seen + 1;
         e = {`EPC_SLAVE_ADDR, 1'b0, 16'h006D, 16'h0001, cmd, arg,
            mission_time_in};
         c = 8'h00;
         for (j = 0; j < 13; j = j + 1) begin
            if (j < 9 || full) begin
               check_byte(m.frame[j], e[103 - 8 * j -: 8]);
            end
            c = crc8(c, m.frame[j]);
         end
         check_byte(m.frame[13], c);
         check_byte(m.nb[7:0], 8'h0E);
      end
   endtask
   // Power-on is refused while the bus voltage is low.
   task t_refuse;
      begin
         bus_voltage_ok_in = 1'b0;
         power_on_req_in = 1'b1;
         tick(20);
         check_byte({7'h00, payload_enable_out}, 8'h00);
         power_on_req_in = 1'b0;
         bus_voltage_ok_in = 1'b1;
      end
   endtask
   // Power-on, quiet settle time, set-time, then run active.
   task t_power_on;
      begin
         power_on_req_in = 1'b1;
         tick(3);
         power_on_req_in = 1'b0;
         check_byte({7'h00, payload_enable_out}, 8'h01);
         check_byte({3'h0, busy_out, seq_state_out}, 8'h11);
         s = m.n_starts;
         tick(SET_C - 5);
         check_byte({7'h00, m.n_starts == s}, 8'h01);
         chk_frame(`EPC_CMD_SET_TIME, reset_count_in, 1'b1);
         chk_frame(`EPC_CMD_SET_RUN, `EPC_RUN_ACTIVE, 1'b0);
         for (i = 0; i < 300 && seq_state_out !== 4'h4; i = i + 1) begin
            tick(1);
         end
         check_byte({3'h0, busy_out, seq_state_out}, 8'h04);
         check_byte({6'h00, scl_out, sda_out}, 8'h00);
      end
   endtask
   // Cease by request or by low voltage, then power off.
   task t_cease(input low);
      begin
         bus_voltage_ok_in = ~low;
         power_off_req_in = ~low;
         chk_frame(`EPC_CMD_SET_RUN, `EPC_RUN_HALT, 1'b0);
         power_off_req_in = 1'b0;
         s = m.n_starts;
         tick(HLT_C - 3);
         check_byte({7'h00, m.n_starts == s}, 8'h01);
         chk_frame(`EPC_CMD_SET_RUN, `EPC_RUN_STANDBY, 1'b0);
         for (i = 0; i < 300 && seq_state_out !== 4'h0; i = i + 1) begin
            tick(1);
         end
         check_byte({7'h00, payload_enable_out}, 8'h00);
         bus_voltage_ok_in = 1'b1;
      end
   endtask
   // A payload that never acknowledges raises the link error flag.
   task t_nack;
      begin
         nack_in = 1'b1;
         power_on_req_in = 1'b1;
         tick(3);
         power_on_req_in = 1'b0;
         for (i = 0; i < 20000 && link_error_out !== 1'b1; i = i + 1) begin
            tick(1);
         end
         check_byte({7'h00, link_error_out}, 8'h01);
         rst_n_in = 1'b0;
         tick(16);
         rst_n_in = 1'b1;
         nack_in = 1'b0;
         check_byte({3'h0, link_error_out, seq_state_out}, 8'h00);
      end
   endtask
   // Print the counts and the verdict, then stop.
   task test_done;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // Main sequence.
   initial begin
      miscompares = 0;
      n_checks = 0;
      seen = 0;
      rst_n_in = 1'b0;
      power_on_req_in = 1'b0;
      power_off_req_in = 1'b0;
      bus_voltage_ok_in = 1'b1;
      nack_in = 1'b0;
      reset_count_in = 16'hA55A;
      mission_time_in = 32'h12C3E4F5;
      tick(16);
      rst_n_in = 1'b1;
      seen = m.n_frames;
      t_refuse;
      t_power_on;
      t_cease(1'b0);
      t_power_on;
      t_cease(1'b1);
      t_nack;
      test_done;
   end
   // Watchdog against a hang, only slightly past the expected run length.
   initial begin
      #3000000;
      miscompares = miscompares + 1;
      test_done;
   end
endmodule
